// [src/wwt_pkg.sv]
// Constants, types and helper functions for the windowed watchdog.
// Assumes an 8-bit register port with a 3-bit word address.
package wwt_pkg;

  // Widths.
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int CNT_W = 14;
  localparam int PRESC_W = 4;

  // Register addresses.
  localparam logic [2:0] A_REFRESH = 3'h0;
  localparam logic [2:0] A_CTRL = 3'h1;
  localparam logic [2:0] A_PROT = 3'h2;
  localparam logic [2:0] A_IRQ = 3'h3;
  localparam logic [2:0] A_START = 3'h4;
  localparam logic [2:0] A_CNT_LO = 3'h5;
  localparam logic [2:0] A_CNT_HI = 3'h6;
  localparam logic [2:0] A_STAT = 3'h7;

  // Control register fields and reset value.
  localparam int CTRL_UFRST_BIT = 0;
  localparam int CTRL_SRC_LO = 6;
  localparam int CTRL_SRC_HI = 7;
  localparam logic [7:0] CTRL_RST = 8'h01;

  // Protection control and periodic interrupt register fields.
  localparam int PROT_EN_BIT = 7;
  localparam int IRQ_FLAG_BIT = 0;
  localparam int IRQ_EN_BIT = 1;

  // Option register fields.
  localparam int OPT1_AUTO_BIT = 0;
  localparam int OPT1_PROT_BIT = 7;
  localparam int OPT2_UF_LO = 2;
  localparam int OPT2_UF_HI = 3;
  localparam int OPT2_WIN_LO = 4;
  localparam int OPT2_WIN_HI = 5;

  // Refresh sequence values.
  localparam logic [7:0] REFRESH_FIRST = 8'h00;
  localparam logic [7:0] REFRESH_SECOND = 8'hff;

  // Count source codes and prescaler terminal count (divide by 16).
  localparam logic [1:0] SRC_CPU = 2'b00;
  localparam logic [3:0] PRESC_LAST = 4'hf;

  // Counter initial values and window codes.
  localparam logic [13:0] INIT_11 = 14'h3fff;
  localparam logic [13:0] INIT_10 = 14'h1fff;
  localparam logic [13:0] INIT_01 = 14'h0fff;
  localparam logic [13:0] INIT_00 = 14'h03ff;
  localparam logic [13:0] CNT_ZERO = 14'h0000;
  localparam logic [13:0] CNT_ONE = 14'h0001;
  localparam logic [1:0] WIN_FULL = 2'b11;
  localparam logic [1:0] WIN_3Q = 2'b10;
  localparam logic [1:0] WIN_HALF = 2'b01;

  typedef enum logic [1:0] {ST_LOAD, ST_STOP, ST_RUN} wwt_state_t;

  // Option settings captured once after reset release.
  typedef struct packed {
    logic prot_init;
    logic autostart;
    logic [1:0] uf_sel;
    logic [1:0] win_sel;
  } wwt_opt_t;

  function automatic logic [13:0] init_val(input logic [1:0] sel);
    logic [13:0] v;
    v = INIT_00;
    unique case (sel)
      2'b11: v = INIT_11;
      2'b10: v = INIT_10;
      2'b01: v = INIT_01;
      2'b00: v = INIT_00;
    endcase
    return v;
  endfunction

  // End of the periodic range: initial value less 0..3 quarters.
  function automatic logic [13:0] end_pt(input logic [13:0] init,
                                         input logic [1:0] win);
    logic [13:0] q;
    logic [13:0] e;
    q = (init >> 2) + CNT_ONE;
    e = init;
    unique case (win)
      2'b11: e = init;
      2'b10: e = init - q;
      2'b01: e = init - (q << 1);
      2'b00: e = init - q - (q << 1);
    endcase
    return e;
  endfunction

endpackage

// [src/wwt_presc.sv]
// Divide-by-16 prescaler for the low-speed oscillator tick.
// Assumes loco_tick is a one-cycle enable synchronous to mclk.
module wwt_presc (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Tick in and out
  input wire logic loco_tick,
  output logic tick16
);

  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic tick_r;
  logic tick_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    tick_nxt = 1'b0;
    if (loco_tick) begin
      cnt_nxt = cnt_r + 4'h1;
      tick_nxt = (cnt_r == wwt_pkg::PRESC_LAST);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 4'h0;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick16 = tick_r;

endmodule

// [src/wwt_top.sv]
// Windowed watchdog and periodic timer with an 8-bit register port.
// Assumes the option bytes are stable during and just after reset and
// that wait_mode, stop_mode and loco_tick are synchronous to mclk.
//
// Overview of operation
// - CPU-clocked count halts in wait/stop unless protection is on.
// - Counter reloads on reset, underflow, or 00h then FFh in window.
// - Underflow gives interrupt or reset; with protection always reset.
// - Two-bit control field selects the count source.
// - Option bit sets protection after reset; else control bit sets it.
// - Option bit selects autostart or stopped after reset.
// - Underflow period field picks 3FFFh, 1FFFh, 0FFFh or 03FFh.
// - Second option register field sets refresh window length.
// - Periodic range ends at the start or one, two or three quarters below it.
// - Leaving the periodic range sets the periodic request flag.
// - No periodic timer function while in stop mode.
// - The counter is 14 bits wide and counts down.
// - Source is CPU or low-speed clock /16; protection uses it undivided.
//
// Added by the designer: strobed register access and the placing of the registers.
module wwt_top (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Option bytes
  input wire logic [7:0] option_reg_one,
  input wire logic [7:0] option_reg_two,
  // Power modes and low-speed oscillator tick
  input wire logic wait_mode,
  input wire logic stop_mode,
  input wire logic loco_tick,
  // Events
  output logic wdt_irq,
  output logic wdt_reset_req,
  output logic periodic_irq
);

  // Reset release synchroniser.
  logic rst_s1_r;
  logic rst_s2_r;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  logic rst_i_n;
  assign rst_i_n = rst_s2_r;

  // Low-speed clock divided by 16.
  logic tick16;

  wwt_presc u_presc (
    .mclk(mclk),
    .rst_n(rst_i_n),
    .loco_tick(loco_tick),
    .tick16(tick16)
  );

  // State.
  wwt_pkg::wwt_state_t state_r;
  wwt_pkg::wwt_state_t state_nxt;
  wwt_pkg::wwt_opt_t opt_r;
  wwt_pkg::wwt_opt_t opt_nxt;
  logic [13:0] cnt_r;
  logic [13:0] cnt_nxt;
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic prot_bit_r;
  logic prot_bit_nxt;
  logic armed_r;
  logic armed_nxt;
  logic pflag_r;
  logic pflag_nxt;
  logic pen_r;
  logic pen_nxt;
  logic irq_r;
  logic irq_nxt;
  logic rstq_r;
  logic rstq_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  // Derived values.
  logic prot_on;
  logic [1:0] src_sel;
  logic [13:0] init_cnt;
  logic [13:0] end_cnt;
  logic halted;
  logic cnt_tick;
  logic in_window;
  logic wr_refresh;

  assign prot_on = opt_r.prot_init | prot_bit_r;
  assign src_sel = ctrl_r[wwt_pkg::CTRL_SRC_HI:wwt_pkg::CTRL_SRC_LO];
  assign init_cnt = wwt_pkg::init_val(opt_r.uf_sel);
  assign end_cnt = wwt_pkg::end_pt(init_cnt, opt_r.win_sel);

  assign halted = !prot_on && (src_sel == wwt_pkg::SRC_CPU) &&
                  (wait_mode || stop_mode);

  always_comb begin
    if (prot_on) begin
      cnt_tick = loco_tick;
    end else if (src_sel == wwt_pkg::SRC_CPU) begin
      cnt_tick = 1'b1;
    end else begin
      cnt_tick = tick16;
    end
  end

  // Refresh is accepted once the count has reached the range end.
  assign in_window = (cnt_r <= end_cnt);
  assign wr_refresh = reg_wr && (reg_addr == wwt_pkg::A_REFRESH);

  always_comb begin
    state_nxt = state_r;
    opt_nxt = opt_r;
    cnt_nxt = cnt_r;
    ctrl_nxt = ctrl_r;
    prot_bit_nxt = prot_bit_r;
    armed_nxt = armed_r;
    pflag_nxt = pflag_r;
    pen_nxt = pen_r;
    irq_nxt = 1'b0;
    rstq_nxt = 1'b0;

    unique case (state_r)
      wwt_pkg::ST_LOAD: begin
        opt_nxt.prot_init = option_reg_one[wwt_pkg::OPT1_PROT_BIT];
        opt_nxt.autostart = option_reg_one[wwt_pkg::OPT1_AUTO_BIT];
        opt_nxt.uf_sel =
          option_reg_two[wwt_pkg::OPT2_UF_HI:wwt_pkg::OPT2_UF_LO];
        opt_nxt.win_sel =
          option_reg_two[wwt_pkg::OPT2_WIN_HI:wwt_pkg::OPT2_WIN_LO];
        cnt_nxt = wwt_pkg::init_val(
          option_reg_two[wwt_pkg::OPT2_UF_HI:wwt_pkg::OPT2_UF_LO]);
        if (option_reg_one[wwt_pkg::OPT1_AUTO_BIT]) begin
          state_nxt = wwt_pkg::ST_RUN;
        end else begin
          state_nxt = wwt_pkg::ST_STOP;
        end
      end
      wwt_pkg::ST_STOP: begin
        if (reg_wr && (reg_addr == wwt_pkg::A_START)) begin
          state_nxt = wwt_pkg::ST_RUN;
        end
      end
      wwt_pkg::ST_RUN: begin
        if (cnt_tick && !halted) begin
          if (cnt_r == wwt_pkg::CNT_ZERO) begin
            cnt_nxt = init_cnt;
            if (prot_on || ctrl_r[wwt_pkg::CTRL_UFRST_BIT]) begin
              rstq_nxt = 1'b1;
            end else begin
              irq_nxt = 1'b1;
            end
          end else begin
            cnt_nxt = cnt_r - wwt_pkg::CNT_ONE;
          end
        end
      end
      default: begin
        state_nxt = wwt_pkg::ST_LOAD;
      end
    endcase

    // Register writes; the option bytes themselves are not writable here.
    if (reg_wr && (state_r != wwt_pkg::ST_LOAD)) begin
      unique case (reg_addr)
        wwt_pkg::A_CTRL: begin
          ctrl_nxt = reg_wdata;
        end
        wwt_pkg::A_PROT: begin
          if (!opt_r.prot_init) begin
            prot_bit_nxt = reg_wdata[wwt_pkg::PROT_EN_BIT];
          end
        end
        wwt_pkg::A_IRQ: begin
          pen_nxt = reg_wdata[wwt_pkg::IRQ_EN_BIT];
          if (!reg_wdata[wwt_pkg::IRQ_FLAG_BIT]) begin
            pflag_nxt = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // Refresh sequence: 00h arms, FFh completes; anything else disarms.
    if (wr_refresh && (state_r != wwt_pkg::ST_LOAD)) begin
      armed_nxt = 1'b0;
      if (reg_wdata == wwt_pkg::REFRESH_FIRST) begin
        armed_nxt = 1'b1;
      end else if ((reg_wdata == wwt_pkg::REFRESH_SECOND) && armed_r) begin
        if (in_window) begin
          cnt_nxt = init_cnt;
        end
      end
    end

    // Set wins over a clear in the same cycle.
    // leaving range sets flag
    if ((state_r == wwt_pkg::ST_RUN) && cnt_tick && !halted &&
        !stop_mode && (cnt_r == end_cnt) &&
        (cnt_r != wwt_pkg::CNT_ZERO)) begin
      pflag_nxt = 1'b1;
    end
  end

  // Read data stands only in the cycle after the read strobe.
  always_comb begin
    rdata_nxt = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        wwt_pkg::A_REFRESH: rdata_nxt = 8'h00;
        wwt_pkg::A_CTRL: rdata_nxt = ctrl_r;
        wwt_pkg::A_PROT: begin
          rdata_nxt = 8'h00;
          rdata_nxt[wwt_pkg::PROT_EN_BIT] = prot_on;
        end
        wwt_pkg::A_IRQ: begin
          rdata_nxt = 8'h00;
          rdata_nxt[wwt_pkg::IRQ_FLAG_BIT] = pflag_r;
          rdata_nxt[wwt_pkg::IRQ_EN_BIT] = pen_r;
        end
        wwt_pkg::A_START: rdata_nxt = 8'h00;
        wwt_pkg::A_CNT_LO: rdata_nxt = cnt_r[7:0];
        wwt_pkg::A_CNT_HI: rdata_nxt = {2'b00, cnt_r[13:8]};
        wwt_pkg::A_STAT: begin
          rdata_nxt = {opt_r.uf_sel, opt_r.win_sel, 1'b0, armed_r,
                       prot_on, (state_r == wwt_pkg::ST_RUN)};
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      state_r <= wwt_pkg::ST_LOAD;
      opt_r <= '0;
      cnt_r <= wwt_pkg::INIT_11;
      ctrl_r <= wwt_pkg::CTRL_RST;
      prot_bit_r <= 1'b0;
      armed_r <= 1'b0;
      pflag_r <= 1'b0;
      pen_r <= 1'b0;
      irq_r <= 1'b0;
      rstq_r <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      opt_r <= opt_nxt;
      cnt_r <= cnt_nxt;
      ctrl_r <= ctrl_nxt;
      prot_bit_r <= prot_bit_nxt;
      armed_r <= armed_nxt;
      pflag_r <= pflag_nxt;
      pen_r <= pen_nxt;
      irq_r <= irq_nxt;
      rstq_r <= rstq_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign wdt_irq = irq_r;
  assign wdt_reset_req = rstq_r;
  // software keeps enable low at full window
  assign periodic_irq = pflag_r & pen_r;

endmodule

// [test/wwt_monitor.sv]
// Port checker for the windowed watchdog top module.
// Assumes the option bytes change only while rst_n is low.
module wwt_monitor (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Options and power mode
  input wire logic [7:0] option_reg_one,
  input wire logic [7:0] option_reg_two,
  input wire logic stop_mode,
  // Events
  input wire logic wdt_irq,
  input wire logic wdt_reset_req,
  input wire logic periodic_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ev;
  logic en_r;
  logic en_nxt;
  assign ev = wdt_irq | wdt_reset_req;
  // Shadow of the periodic enable, as software last wrote it.
  always_comb begin
    en_nxt = en_r;
    if (reg_wr && reg_addr == wwt_pkg::A_IRQ) begin
      en_nxt = reg_wdata[wwt_pkg::IRQ_EN_BIT];
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      en_r <= 1'b0;
    end else begin
      en_r <= en_nxt;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // The shortest period is 400h ticks, so eight quiet cycles is safe.
  sequence s_quiet;
    !ev [*8];
  endsequence
  sequence s_stat_rd;
    reg_rd && reg_addr == wwt_pkg::A_STAT;
  endsequence
  a_one_action: assert property (!(wdt_irq && wdt_reset_req))
    else $error("interrupt and reset together");
  a_event_gap: assert property (ev |=> s_quiet)
    else $error("underflow did not reload");
  a_prot_action: assert property
    (option_reg_one[wwt_pkg::OPT1_PROT_BIT] |-> !wdt_irq)
    else $error("interrupt while protection forced");
  a_quiet_reset: assert property (disable iff (1'b0)
    !rst_n |-> !ev && !periodic_irq && reg_rdata == 8'h00)
    else $error("output active in reset");
  a_irq_gate: assert property (periodic_irq |-> en_r)
    else $error("periodic request while disabled");
  a_stop_no_period: assert property
    ($rose(periodic_irq) && $past(en_r) |-> !$past(stop_mode))
    else $error("periodic flag set in stop mode");
  a_prot_readback: assert property
    (reg_rd && reg_addr == wwt_pkg::A_PROT &&
     option_reg_one[wwt_pkg::OPT1_PROT_BIT] |=> reg_rdata[7])
    else $error("forced protection reads back off");
  a_stat_fields: assert property (s_stat_rd |=>
    reg_rdata[7:4] == {option_reg_two[3:2], option_reg_two[5:4]})
    else $error("status option fields wrong");
endmodule

// [test/wwt_top_bench.sv]
// Self-checking bench for the windowed watchdog top module.
// Assumes wwt_pkg, the design and wwt_monitor are compiled first.
module wwt_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, rst_n, reg_wr, reg_rd, wait_mode, stop_mode, loco_tick;
  logic loco_on, wdt_irq, wdt_reset_req, periodic_irq;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, option_reg_one, option_reg_two, d;
  logic [13:0] c, c2;
  logic [1:0] k, w;
  logic [13:0] inits [4] = '{14'h03ff, 14'h0fff, 14'h1fff, 14'h3fff};
  int errors, n_checks, n, q, u;
  wwt_top i_wwt_top (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .option_reg_one(option_reg_one),
    .option_reg_two(option_reg_two), .wait_mode(wait_mode),
    .stop_mode(stop_mode), .loco_tick(loco_tick), .wdt_irq(wdt_irq),
    .wdt_reset_req(wdt_reset_req), .periodic_irq(periodic_irq));
  always #50 mclk = ~mclk;
  always @(posedge mclk) loco_tick <= loco_on & ~loco_tick;
  task automatic chk(input string s, input logic [15:0] e,
    input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // An idle edge follows each strobe, so tasks may be chained freely.
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    v = reg_rdata;
    @(posedge mclk);
  endtask
  task automatic rd_cnt(output logic [13:0] v);
    logic [7:0] lo;
    logic [7:0] hi;
    rd(wwt_pkg::A_CNT_LO, lo);
    rd(wwt_pkg::A_CNT_HI, hi);
    v = {hi[5:0], lo};
  endtask
  task automatic refresh;
    wr(wwt_pkg::A_REFRESH, wwt_pkg::REFRESH_FIRST);
    wr(wwt_pkg::A_REFRESH, wwt_pkg::REFRESH_SECOND);
  endtask
  task automatic rst(input logic [7:0] o1, input logic [7:0] o2);
    rst_n <= 1'b0;
    option_reg_one <= o1;
    option_reg_two <= o2;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
  endtask
  // Counts cycles until an event, or the periodic request when pi is set.
  task automatic wt(input int lim, input bit pi);
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while ((pi ? periodic_irq : wdt_irq | wdt_reset_req) !== 1'b1
               && n < lim);
    k = {wdt_reset_req, wdt_irq};
    if (n >= lim) begin
      chk("wait bound", 16'h1, 16'h0);
      report_and_stop();
    end
    @(posedge mclk);
  endtask
  initial begin
    {mclk, reg_wr, reg_rd, wait_mode, stop_mode} = '0;
    {loco_on, reg_addr, reg_wdata} = '0;
    {option_reg_one, option_reg_two} = '0;
    rst_n = 1'b1;
    void'($urandom(52));
    // A real falling reset edge before the first clock edge, so that no
    // flop is still unknown when the checker first samples.
    #10 rst_n = 1'b0;
    @(posedge mclk);
    for (u = 0; u < 4; u++) begin
      w = 2'($urandom_range(2));
      rst(8'h00, {2'b00, w, 2'(u), 2'b00});
      rd_cnt(c);
      chk("stopped count", 16'(inits[u]), 16'(c));
      rd(wwt_pkg::A_STAT, d);
      chk("status", {8'h00, 2'(u), w, 4'h0},
        {8'h00, d[7:4], 2'b00, d[1:0]});
    end
    rd(wwt_pkg::A_CTRL, d);
    chk("control", 16'h01, 16'(d));
    wr(wwt_pkg::A_START, 8'h00);
    rd_cnt(c);
    chk("count down", 16'h1, 16'(c < 14'h3fff && c > 14'h3fd0));
    for (int m = 1; m < 3; m++) begin
      {stop_mode, wait_mode} <= 2'(m);
      rd_cnt(c);
      repeat (20) @(posedge mclk);
      rd_cnt(c2);
      chk("halted count", 16'(c), 16'(c2));
    end
    {stop_mode, wait_mode} <= 2'b00;
    loco_on <= 1'b1;
    for (int s = 1; s < 4; s++) begin
      wr(wwt_pkg::A_CTRL, {2'(s), 6'h01});
      rd_cnt(c);
      repeat (320) @(posedge mclk);
      rd_cnt(c2);
      q = int'(c - c2);
      chk("divided rate", 16'h1, 16'(q >= 9 && q <= 11));
    end
    loco_on <= 1'b0;
    rst(8'h01, 8'h00);
    wr(wwt_pkg::A_CTRL, 8'h00);
    wt(1100, 0);
    wt(1100, 0);
    chk("period", 16'd1024, 16'(n));
    chk("irq action", 16'h1, 16'(k));
    repeat (100) @(posedge mclk);
    refresh();
    wt(1100, 0);
    chk("early refresh", 16'h1, 16'(n < 1000));
    repeat (900) @(posedge mclk);
    refresh();
    wt(1100, 0);
    chk("window refresh", 16'h1, 16'(n > 1000));
    wr(wwt_pkg::A_CTRL, 8'h01);
    wt(1100, 0);
    chk("reset action", 16'h2, 16'(k));
    u = $urandom_range(1);
    w = 2'($urandom_range(2));
    rst(8'h01, {2'b00, w, 2'(u), 2'b00});
    wr(wwt_pkg::A_CTRL, 8'h00);
    q = (int'(inits[u]) + 1) / 4 * (3 - int'(w));
    wt(4200, 0);
    wr(wwt_pkg::A_IRQ, 8'h02);
    wt(q + 10, 1);
    chk("periodic end", 16'h1, 16'(n >= q - 3 && n <= q + 1));
    wr(wwt_pkg::A_IRQ, 8'h00);
    repeat (2 * int'(inits[u]) + 4) @(posedge mclk);
    chk("masked", 16'h0, 16'(periodic_irq));
    // Bit 0 written as 1 leaves the pending flag alone.
    wr(wwt_pkg::A_IRQ, 8'h03);
    @(negedge mclk);
    chk("flag kept", 16'h1, 16'(periodic_irq));
    @(posedge mclk);
    loco_on <= 1'b1;
    {stop_mode, wait_mode} <= 2'b11;
    rst(8'h81, 8'h20);
    wr(wwt_pkg::A_CTRL, 8'h00);
    wr(wwt_pkg::A_PROT, 8'h00);
    wr(wwt_pkg::A_IRQ, 8'h02);
    rd(wwt_pkg::A_PROT, d);
    chk("forced prot", 16'h1, 16'(d[7]));
    wt(2300, 0);
    chk("prot action", 16'h2, 16'(k));
    chk("stop periodic", 16'h0, 16'(periodic_irq));
    {stop_mode, wait_mode} <= 2'b00;
    rst(8'h00, 8'h00);
    wr(wwt_pkg::A_PROT, 8'h80);
    rd(wwt_pkg::A_PROT, d);
    chk("soft prot", 16'h1, 16'(d[7]));
    report_and_stop();
  end
endmodule
bind wwt_top wwt_monitor i_wwt_monitor (.mclk(mclk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .option_reg_one(option_reg_one),
  .option_reg_two(option_reg_two), .stop_mode(stop_mode),
  .wdt_irq(wdt_irq), .wdt_reset_req(wdt_reset_req),
  .periodic_irq(periodic_irq));
